// *** csia_core.sv ***
`timescale 1ns/1ps
// Functional notes
// RULE1 - A sixteen-entry, fifteen-bit return stack holds return addresses.
// RULE2 - Push when full sets overflow; pop when empty sets underflow.
// RULE3 - With stack-error reset enabled, either error pulses soft reset.
// RULE4 - Two 16-bit pointers reach data and program memory in one space.
// RULE5 - A port read through a pointer into program memory adds a cycle.
// RULE6 - Pointers address general-purpose RAM linearly across banks.
// RULE7 - Eight banks 80h apart mirror core registers at offsets 0 to 0Bh. The code keeps writes at 03h to 0Ah only.
// RULE8 - Interrupt entry saves context; return restores it automatically.
// RULE9 - The decoder served has forty-nine instructions.
// RULE10 - Direct address is bank select joined with a 7-bit offset.
module csia_core
   import csia_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Core execute requests
   input wire logic call_i,
   input wire logic ret_i,
   input wire logic [14:0] ret_addr_i,
   input wire logic int_entry_i,
   input wire logic int_return_i,
   input wire logic dir_we_i,
   input wire logic [6:0] dir_ofs_i,
   input wire logic [7:0] dir_wdata_i,
   input wire logic ind_rd_i,
   input wire logic ind_sel_i,
   input wire logic [5:0] opcode_idx_i,
   // Memory side
   input wire logic [7:0] mem_rdata_i,
   input wire logic [7:0] prog_rdata_i,
   // Core results
   output logic [14:0] ret_top_o,
   output logic [9:0] data_addr_o,
   output logic [14:0] prog_addr_o,
   output logic ind_is_prog_o,
   output logic stall_o,
   output logic [7:0] ind_rdata_o,
   output logic ind_valid_o,
   output logic soft_reset_o,
   output logic opcode_ok_o,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef enum logic [1:0] {
      CSIA_IDLE = 2'b00,
      CSIA_FETCH = 2'b01
   } csia_ind_e;

   // ==================================================
   // State
   csia_ctx_s ctx_q, ctx_d, saved;
   logic ovf_q, ovf_d, unf_q, unf_d;
   logic stkrst_q, stkrst_d;
   logic srst_q, srst_d;
   csia_ind_e ist_q, ist_d;
   logic [7:0] ird_q, ird_d;
   logic ivld_q, ivld_d;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic [15:0] iptr;
   logic [14:0] lin_off;
   logic sw_wr, sw_clr_ovf, sw_clr_unf;
   logic [31:0] rd_mux;
   logic rd_ok;

   csia_stk_if stk();

   // ==================================================
   // Return stack and shadow
   assign stk.push = call_i | int_entry_i;
   assign stk.pop = ret_i | int_return_i;
   assign stk.wdata = ret_addr_i; // RULE1

   csia_stack #(.DEPTH(CSIA_STACK_DEPTH), .WIDTH(CSIA_STACK_WIDTH))
   u_stack (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .stk(stk.stack)
   );

   csia_shadow u_shadow (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .save_i(int_entry_i),
      .live_i(ctx_q),
      .saved_o(saved)
   );

   assign ret_top_o = stk.top;

   // ==================================================
   // Address forming
   assign iptr = ind_sel_i ? ctx_q.ptr1 : ctx_q.ptr0;
   assign lin_off = iptr[14:0] - CSIA_LINEAR_BASE[14:0];
   always_comb begin
      data_addr_o = {ctx_q.bank[2:0], dir_ofs_i}; // RULE10
      if (ind_rd_i) begin
         if (iptr >= CSIA_LINEAR_BASE && iptr < CSIA_LINEAR_END) begin
            // RULE6
            data_addr_o = 10'({lin_off / 15'(CSIA_GPR_BYTES), 7'h00})
               + 10'(CSIA_GPR_FIRST)
               + 10'(lin_off % 15'(CSIA_GPR_BYTES));
         end else begin
            data_addr_o = iptr[9:0]; // RULE4
         end
      end
   end
   assign ind_is_prog_o = iptr >= CSIA_PROG_BASE; // RULE4
   assign prog_addr_o = iptr[14:0];
   assign opcode_ok_o = opcode_idx_i < 6'(CSIA_NUM_INSTR); // RULE9

   // ==================================================
   // Indirect read sequencer; program reads take one extra cycle
   always_comb begin
      ist_d = ist_q;
      ird_d = ird_q;
      ivld_d = 1'b0;
      stall_o = 1'b0;
      case (ist_q)
         CSIA_IDLE: begin
            if (ind_rd_i && ind_is_prog_o) begin
               ist_d = CSIA_FETCH; // RULE5
               stall_o = 1'b1; // RULE5
            end else if (ind_rd_i) begin
               ird_d = mem_rdata_i;
               ivld_d = 1'b1;
            end
         end
         CSIA_FETCH: begin
            ird_d = prog_rdata_i; // RULE5
            ivld_d = 1'b1;
            ist_d = CSIA_IDLE;
         end
         default: ist_d = CSIA_IDLE;
      endcase
   end
   assign ind_rdata_o = ird_q;
   assign ind_valid_o = ivld_q;

   // ==================================================
   // Core registers: one physical copy per offset 03h to 0Ah, any bank
   always_comb begin
      ctx_d = ctx_q;
      if (int_return_i) begin
         ctx_d = saved; // RULE8
      end else if (dir_we_i && dir_ofs_i <= CSIA_OFS_CORE_LAST) begin
         case (dir_ofs_i) // RULE7
            CSIA_OFS_STATUS_FLAGS: ctx_d.status = dir_wdata_i;
            CSIA_OFS_POINTER0_LOW: ctx_d.ptr0[7:0] = dir_wdata_i;
            CSIA_OFS_POINTER0_HIGH: ctx_d.ptr0[15:8] = dir_wdata_i;
            CSIA_OFS_POINTER1_LOW: ctx_d.ptr1[7:0] = dir_wdata_i;
            CSIA_OFS_POINTER1_HIGH: ctx_d.ptr1[15:8] = dir_wdata_i;
            CSIA_OFS_BANK_SELECT: ctx_d.bank = dir_wdata_i;
            CSIA_OFS_WORKING_ACCUMULATOR: ctx_d.acc = dir_wdata_i;
            CSIA_OFS_PROGRAM_COUNTER_LATCH_HIGH: ctx_d.pc_latch = dir_wdata_i;
            default: ctx_d = ctx_q;
         endcase
      end
      if (sw_wr && awa_q == CSIA_AXI_PTR0) begin
         ctx_d.ptr0 = wd_q[15:0];
      end
      if (sw_wr && awa_q == CSIA_AXI_PTR1) begin
         ctx_d.ptr1 = wd_q[15:0];
      end
      if (sw_wr && awa_q == CSIA_AXI_BANK) begin
         ctx_d.bank = {5'h00, wd_q[2:0]};
      end
   end

   // ==================================================
   // Stack error flags: a new event wins over a clear
   assign sw_clr_ovf = sw_wr && awa_q == CSIA_AXI_STAT
      && wd_q[CSIA_STAT_OVF_BIT];
   assign sw_clr_unf = sw_wr && awa_q == CSIA_AXI_STAT
      && wd_q[CSIA_STAT_UNF_BIT];
   always_comb begin
      ovf_d = stk.ovf | (ovf_q & ~sw_clr_ovf); // RULE2
      unf_d = stk.unf | (unf_q & ~sw_clr_unf); // RULE2
      stkrst_d = stkrst_q;
      if (sw_wr && awa_q == CSIA_AXI_CTRL) begin
         stkrst_d = wd_q[CSIA_CTRL_STKRST_BIT];
      end
      srst_d = stkrst_q & (stk.ovf | stk.unf); // RULE3
   end
   assign soft_reset_o = srst_q;

   // ==================================================
   // AXI4-Lite: address and data taken in either order
   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready = !w_q && !bv_q;
   assign s_axi_arready = !rv_q;
   assign sw_wr = aw_q && w_q && !bv_q;
   always_comb begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         CSIA_AXI_CTRL: rd_mux = {31'h0, stkrst_q};
         CSIA_AXI_STAT: rd_mux = {24'h0, ovf_q, unf_q, 6'h00};
         CSIA_AXI_PTR0: rd_mux = {16'h0, ctx_q.ptr0};
         CSIA_AXI_PTR1: rd_mux = {16'h0, ctx_q.ptr1};
         CSIA_AXI_BANK: rd_mux = {24'h0, ctx_q.bank};
         CSIA_AXI_SHADOW: rd_mux = {8'h0, saved.status, saved.acc,
            saved.bank};
         default: begin
            rd_mux = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      bv_d = bv_q;
      awa_d = awa_q;
      wd_d = wd_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
      end
      if (sw_wr) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = (awa_q <= CSIA_AXI_BANK && awa_q[1:0] == 2'b00)
            ? CSIA_RESP_OKAY : CSIA_RESP_SLVERR;
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rd_d = rd_mux;
         rr_d = rd_ok ? CSIA_RESP_OKAY : CSIA_RESP_SLVERR;
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;

   // ==================================================
   // Registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctx_q <= '0;
         ovf_q <= 1'b0;
         unf_q <= 1'b0;
         stkrst_q <= 1'b0;
         srst_q <= 1'b0;
         ist_q <= CSIA_IDLE;
         ird_q <= CSIA_RST_BYTE;
         ivld_q <= 1'b0;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bv_q <= 1'b0;
         rv_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h0;
         rd_q <= 32'h0;
         br_q <= CSIA_RESP_OKAY;
         rr_q <= CSIA_RESP_OKAY;
      end else begin
         ctx_q <= ctx_d;
         ovf_q <= ovf_d;
         unf_q <= unf_d;
         stkrst_q <= stkrst_d;
         srst_q <= srst_d;
         ist_q <= ist_d;
         ird_q <= ird_d;
         ivld_q <= ivld_d;
         aw_q <= aw_d;
         w_q <= w_d;
         bv_q <= bv_d;
         rv_q <= rv_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         br_q <= br_d;
         rr_q <= rr_d;
      end
   end
endmodule : csia_core

// *** csia_pkg.sv ***
package csia_pkg;
   // ==================================================
   // Core register offsets, mirrored in every bank
   localparam logic [6:0] CSIA_OFS_INDIRECT_PORT_0 = 7'h00;
   localparam logic [6:0] CSIA_OFS_INDIRECT_PORT_1 = 7'h01;
   localparam logic [6:0] CSIA_OFS_PROGRAM_COUNTER_LOW = 7'h02;
   localparam logic [6:0] CSIA_OFS_STATUS_FLAGS = 7'h03;
   localparam logic [6:0] CSIA_OFS_POINTER0_LOW = 7'h04;
   localparam logic [6:0] CSIA_OFS_POINTER0_HIGH = 7'h05;
   localparam logic [6:0] CSIA_OFS_POINTER1_LOW = 7'h06;
   localparam logic [6:0] CSIA_OFS_POINTER1_HIGH = 7'h07;
   localparam logic [6:0] CSIA_OFS_BANK_SELECT = 7'h08;
   localparam logic [6:0] CSIA_OFS_WORKING_ACCUMULATOR = 7'h09;
   localparam logic [6:0] CSIA_OFS_PROGRAM_COUNTER_LATCH_HIGH = 7'h0a;
   localparam logic [6:0] CSIA_OFS_INTERRUPT_CONTROL = 7'h0b;
   localparam logic [6:0] CSIA_OFS_CORE_LAST = 7'h0b;
   // ==================================================
   // Bank layout
   localparam int CSIA_NUM_BANKS = 8;
   localparam logic [7:0] CSIA_BANK_STRIDE = 8'h80;
   localparam logic [6:0] CSIA_GPR_FIRST = 7'h20;
   localparam logic [6:0] CSIA_GPR_LAST = 7'h6f;
   localparam logic [7:0] CSIA_GPR_BYTES = 8'h50;
   // Linear window of general-purpose RAM in pointer space
   localparam logic [15:0] CSIA_LINEAR_BASE = 16'h2000;
   localparam logic [15:0] CSIA_LINEAR_END = 16'h2280;
   // Pointer values at or above this reach program memory
   localparam logic [15:0] CSIA_PROG_BASE = 16'h8000;
   // ==================================================
   // Stack and instruction set
   localparam int CSIA_STACK_DEPTH = 16;
   localparam int CSIA_STACK_WIDTH = 15;
   localparam int CSIA_NUM_INSTR = 49;
   // ==================================================
   // AXI register map (byte addresses)
   localparam logic [7:0] CSIA_AXI_CTRL = 8'h00;
   localparam logic [7:0] CSIA_AXI_STAT = 8'h04;
   localparam logic [7:0] CSIA_AXI_PTR0 = 8'h08;
   localparam logic [7:0] CSIA_AXI_PTR1 = 8'h0c;
   localparam logic [7:0] CSIA_AXI_BANK = 8'h10;
   localparam logic [7:0] CSIA_AXI_SHADOW = 8'h14;
   // Control bits
   localparam int CSIA_CTRL_STKRST_BIT = 0;
   // Status bits in the power control register image
   localparam int CSIA_STAT_OVF_BIT = 7;
   localparam int CSIA_STAT_UNF_BIT = 6;
   // Reset values
   localparam logic [7:0] CSIA_RST_BYTE = 8'h00;
   localparam logic [14:0] CSIA_RST_PC = 15'h0000;
   localparam logic [1:0] CSIA_RESP_OKAY = 2'b00;
   localparam logic [1:0] CSIA_RESP_SLVERR = 2'b10;
   // Shadowed context
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] acc;
      logic [7:0] bank;
      logic [7:0] pc_latch;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
   } csia_ctx_s;
endpackage : csia_pkg

// *** csia_stk_if.sv ***
`timescale 1ns/1ps
// Push and pop requests between the core and the return stack
interface csia_stk_if;
   logic push;
   logic pop;
   logic [14:0] wdata;
   logic [14:0] top;
   logic ovf;
   logic unf;
   modport core (output push, output pop, output wdata,
      input top, input ovf, input unf);
   modport stack (input push, input pop, input wdata,
      output top, output ovf, output unf);
endinterface : csia_stk_if

// *** csia_stack.sv ***
`timescale 1ns/1ps
// ==================================================
// Return stack with overflow and underflow detection
module csia_stack
   import csia_pkg::*;
#(
   parameter int DEPTH = CSIA_STACK_DEPTH,
   parameter int WIDTH = CSIA_STACK_WIDTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Core side
   csia_stk_if.stack stk
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW:0] cnt_q, cnt_d;
   logic [PW-1:0] wr_idx;
   logic ovf_ev, unf_ev;

   // Overflow on a push when full, underflow on a pop when empty
   always_comb begin
      cnt_d = cnt_q;
      ovf_ev = 1'b0;
      unf_ev = 1'b0;
      wr_idx = cnt_q[PW-1:0];
      if (stk.push && !stk.pop) begin
         if (cnt_q == (PW+1)'(DEPTH)) begin
            ovf_ev = 1'b1; // RULE2
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end else if (stk.pop && !stk.push) begin
         if (cnt_q == '0) begin
            unf_ev = 1'b1; // RULE2
         end else begin
            cnt_d = cnt_q - 1'b1;
         end
      end
   end

   // Storage; a full push drops the word rather than wrapping
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   genvar g;
   for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            mem_q[g] <= '0;
         end else if (stk.push && !stk.pop
               && cnt_q != (PW+1)'(DEPTH) && wr_idx == PW'(g)) begin
            mem_q[g] <= stk.wdata; // RULE1
         end
      end
   end

   assign stk.top = (cnt_q == '0) ? '0 : mem_q[PW'(cnt_q - 1'b1)];
   assign stk.ovf = ovf_ev;
   assign stk.unf = unf_ev;
endmodule : csia_stack

// *** csia_shadow.sv ***
`timescale 1ns/1ps
// ==================================================
// Shadow copy of core context taken on interrupt entry
module csia_shadow
   import csia_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Control
   input wire logic save_i,
   input wire csia_ctx_s live_i,
   // Saved context
   output csia_ctx_s saved_o
);
   csia_ctx_s sh_q, sh_d;

   // Capture only on entry; return just reads the copy
   always_comb begin
      sh_d = sh_q;
      if (save_i) begin
         sh_d = live_i; // RULE8
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sh_q <= '0;
      end else begin
         sh_q <= sh_d;
      end
   end

   assign saved_o = sh_q;
endmodule : csia_shadow

// *** csia_mem_model.sv ***
`timescale 1ns/1ps
// ==================================================
// Memory side of the core: data RAM and program memory
module csia_mem_model (
   // Addresses from the core
   input wire logic [9:0] data_addr_i,
   input wire logic [14:0] prog_addr_i,
   // Read data, answered in the same cycle
   output logic [7:0] mem_rdata_o,
   output logic [7:0] prog_rdata_o
);
   // Contents follow the address, so a wrong address shows as wrong data
   assign mem_rdata_o = data_addr_i[7:0] ^ {data_addr_i[9:8], 6'h00} ^ 8'h5a;
   assign prog_rdata_o = prog_addr_i[7:0] ^ {1'b0, prog_addr_i[14:8]} ^ 8'ha5;
endmodule : csia_mem_model

// *** csia_core_assertions.sv ***
`timescale 1ns/1ps
// ==================================================
// Port checks of the core
module csia_core_assertions
   import csia_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Core side
   input wire logic call_i,
   input wire logic ret_i,
   input wire logic int_entry_i,
   input wire logic int_return_i,
   input wire logic [14:0] ret_addr_i,
   input wire logic ind_rd_i,
   input wire logic [5:0] opcode_idx_i,
   input wire logic [7:0] prog_rdata_i,
   input wire logic [14:0] ret_top_o,
   input wire logic ind_is_prog_o,
   input wire logic stall_o,
   input wire logic [7:0] ind_rdata_o,
   input wire logic ind_valid_o,
   input wire logic soft_reset_o,
   input wire logic opcode_ok_o,
   // Bus side
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   default clocking dcb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic [4:0] depth_q, depth_d;
   logic push, pop, err;
   // Fill level; simultaneous push and pop leaves it alone
   assign push = call_i | int_entry_i;
   assign pop = ret_i | int_return_i;
   assign err = (push && !pop && depth_q == 5'd16) ||
      (pop && !push && depth_q == 5'd0);
   always_comb begin
      depth_d = depth_q;
      if (push && !pop && depth_q != 5'd16) depth_d = depth_q + 5'd1;
      else if (pop && !push && depth_q != 5'd0) depth_d = depth_q - 5'd1;
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) depth_q <= 5'd0;
      else depth_q <= depth_d;
   end
   // ==================================================
   // Assertions
   opcode_range_a: assert property (
      opcode_ok_o == (opcode_idx_i < 6'd49)) else $error("opcode flag wrong");
   push_top_a: assert property (
      push && !pop && depth_q < 5'd16 |=> ret_top_o == $past(ret_addr_i))
      else $error("pushed address not on top");
   full_drop_a: assert property (
      push && !pop && depth_q == 5'd16 |=> $stable(ret_top_o))
      else $error("push into full stack changed top");
   empty_top_a: assert property (
      depth_q == 5'd0 |-> ret_top_o == 15'h0000)
      else $error("empty stack top not zero");
   prog_stall_a: assert property (
      stall_o |-> ind_rd_i && ind_is_prog_o) else $error("stray stall");
   prog_wait_a: assert property (
      stall_o |-> ##2 (ind_valid_o && ind_rdata_o == $past(prog_rdata_i)))
      else $error("program read result late or wrong");
   soft_cause_a: assert property (
      soft_reset_o |-> $past(err) || $past(err, 2))
      else $error("soft reset without stack error");
   bresp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   rresp_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read response dropped");
   read_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer missing");
   // Main scenarios reached
   stall_c: cover property (stall_o);
   soft_c: cover property (soft_reset_o);
   full_c: cover property (push && depth_q == 5'd16);
endmodule : csia_core_assertions

// *** tb.sv ***
`timescale 1ns/1ps
// ==================================================
// Self-checking bench of the core
module tb
   import csia_pkg::*;
;
   logic clk_i = 0, nrst_i = 0, call_i = 0, ret_i = 0, int_entry_i = 0;
   logic int_return_i = 0, dir_we_i = 0, ind_rd_i = 0, ind_sel_i = 0;
   logic [14:0] ret_addr_i = 0, ret_top_o, prog_addr_o;
   logic [6:0] dir_ofs_i = 0;
   logic [7:0] dir_wdata_i = 0, mem_rdata_i, prog_rdata_i, ind_rdata_o;
   logic [5:0] opcode_idx_i = 0;
   logic [9:0] data_addr_o;
   logic ind_is_prog_o, stall_o, ind_valid_o, soft_reset_o, opcode_ok_o;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int num_errors = 0, n_compared = 0, sr_cnt = 0;
   int corner [4] = '{0, 79, 80, 639};
   csia_core dut (.*);
   csia_mem_model mem (.data_addr_i(data_addr_o), .prog_addr_i(prog_addr_o),
      .mem_rdata_o(mem_rdata_i), .prog_rdata_o(prog_rdata_i));
   // Clock and soft reset pulse counter
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (soft_reset_o === 1'b1) sr_cnt <= sr_cnt + 1;
   // Cuts a hang short; the whole run needs well under this
   initial begin
      #100us;
      num_errors++;
      wrap_up();
   end
   // ==================================================
   // Expectations and comparison
   function automatic logic [14:0] lin(input int k);
      return {5'h00, 3'(k / int'(CSIA_GPR_BYTES)),
         7'(int'(CSIA_GPR_FIRST) + k % int'(CSIA_GPR_BYTES))};
   endfunction : lin
   function automatic logic [7:0] exp_rd(input logic [14:0] e, input logic p);
      if (p) return e[7:0] ^ {1'b0, e[14:8]} ^ 8'ha5;
      return e[7:0] ^ {e[9:8], 6'h00} ^ 8'h5a;
   endfunction : exp_rd
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   // ==================================================
   // Drivers
   task automatic do_reset;
      nrst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
   endtask : do_reset
   // Response ready is raised late at random to exercise the hold
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      int w;
      w = $urandom_range(2);
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         if (w == 0) s_axi_bready <= 1'b1;
         else w--;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int w;
      w = $urandom_range(2);
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (w == 0) s_axi_rready <= 1'b1;
         else w--;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic wok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk("bresp", CSIA_RESP_OKAY, r);
   endtask : wok
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk("rdata", e, d);
      chk("rresp", CSIA_RESP_OKAY, r);
   endtask : rchk
   task automatic dw(input logic [6:0] o, input logic [7:0] v,
      input logic [2:0] b);
      @(posedge clk_i);
      dir_we_i <= 1'b1;
      dir_ofs_i <= o;
      dir_wdata_i <= v;
      @(negedge clk_i);
      chk("dir_addr", {b, o}, data_addr_o);
      @(posedge clk_i);
      dir_we_i <= 1'b0;
   endtask : dw
   // Request held until the stall clears, then result one edge later
   task automatic ind_chk(input logic s, input logic [14:0] e, input logic p);
      @(posedge clk_i);
      ind_rd_i <= 1'b1;
      ind_sel_i <= s;
      @(negedge clk_i);
      chk("is_prog", p, ind_is_prog_o);
      chk("ind_addr", e, p ? prog_addr_o : {5'h00, data_addr_o});
      do @(posedge clk_i); while (stall_o === 1'b1);
      ind_rd_i <= 1'b0;
      #1;
      chk("ind_valid", 1, ind_valid_o);
      chk("ind_rdata", exp_rd(e, p), ind_rdata_o);
   endtask : ind_chk
   // ==================================================
   // Tests
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [14:0] a [17];
      logic [7:0] v;
      logic [2:0] b;
      int k;
      void'($urandom(39346));
      do_reset();
      rchk(CSIA_AXI_STAT, 32'h0);
      rchk(CSIA_AXI_CTRL, 32'h0);
      rd(8'h40, d, r);
      chk("unmapped_rresp", CSIA_RESP_SLVERR, r);
      chk("unmapped_rdata", 0, d);
      wr(8'h44, 32'h1, r);
      chk("unmapped_bresp", CSIA_RESP_SLVERR, r);
      for (k = 0; k < 64; k++) begin
         @(posedge clk_i);
         opcode_idx_i <= 6'(k);
         @(negedge clk_i);
         chk("opcode_ok", k < CSIA_NUM_INSTR, opcode_ok_o);
      end
      $display("test registers and decoder done");
      // Fill past the top, then drain past the bottom
      foreach (a[i]) a[i] = 15'($urandom);
      @(posedge clk_i);
      call_i <= 1'b1;
      ret_addr_i <= a[0];
      for (k = 0; k < 17; k++) begin
         @(posedge clk_i);
         if (k < 16) ret_addr_i <= a[k + 1];
         else call_i <= 1'b0;
         @(negedge clk_i);
         chk("push_top", a[k < 16 ? k : 15], ret_top_o);
      end
      rchk(CSIA_AXI_STAT, 32'h80);
      ret_i <= 1'b1;
      for (k = 0; k < 17; k++) begin
         @(posedge clk_i);
         if (k == 16) ret_i <= 1'b0;
         @(negedge clk_i);
         chk("pop_top", k < 15 ? a[14 - k] : 15'h0, ret_top_o);
      end
      rchk(CSIA_AXI_STAT, 32'hc0);
      wok(CSIA_AXI_STAT, 32'hc0);
      rchk(CSIA_AXI_STAT, 32'h0);
      chk("soft_reset_off", 0, sr_cnt);
      $display("test stack done");
      for (k = 0; k < 8; k++) begin
         b = 3'(k);
         v = 8'($urandom);
         wok(CSIA_AXI_BANK, {29'h0, b});
         dw(CSIA_OFS_POINTER0_LOW, v, b);
         rd(CSIA_AXI_PTR0, d, r);
         chk("ptr0_low", v, d[7:0]);
         dw(CSIA_OFS_BANK_SELECT, {5'h00, ~b}, b);
         rchk(CSIA_AXI_BANK, {29'h0, ~b});
      end
      $display("test bank mirror done");
      for (int i = 0; i < 8; i++) begin
         k = i < 4 ? corner[i] : int'($urandom_range(639));
         wok(i[0] ? CSIA_AXI_PTR1 : CSIA_AXI_PTR0, 32'(CSIA_LINEAR_BASE) + k);
         ind_chk(i[0], lin(k), 1'b0);
         a[0] = 15'($urandom);
         wok(i[0] ? CSIA_AXI_PTR0 : CSIA_AXI_PTR1, {16'h0, 1'b1, a[0]});
         ind_chk(!i[0], a[0], 1'b1);
      end
      $display("test indirect done");
      v = 8'($urandom);
      b = 3'($urandom);
      a[1] = 15'($urandom);
      wok(CSIA_AXI_BANK, {29'h0, b});
      dw(CSIA_OFS_WORKING_ACCUMULATOR, v, b);
      wok(CSIA_AXI_PTR0, {17'h0, a[1]});
      @(posedge clk_i);
      int_entry_i <= 1'b1;
      @(posedge clk_i);
      int_entry_i <= 1'b0;
      wok(CSIA_AXI_BANK, {29'h0, ~b});
      dw(CSIA_OFS_WORKING_ACCUMULATOR, ~v, ~b);
      wok(CSIA_AXI_PTR0, 32'h0);
      rd(CSIA_AXI_SHADOW, d, r);
      chk("shadow", {v, 5'h00, b}, d[15:0]);
      @(posedge clk_i);
      int_return_i <= 1'b1;
      @(posedge clk_i);
      int_return_i <= 1'b0;
      rchk(CSIA_AXI_BANK, {29'h0, b});
      rchk(CSIA_AXI_PTR0, {17'h0, a[1]});
      $display("test context save done");
      wok(CSIA_AXI_CTRL, 32'h1);
      @(posedge clk_i);
      ret_i <= 1'b1;
      @(posedge clk_i);
      ret_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("soft_reset_on", 1, sr_cnt);
      do_reset();
      rchk(CSIA_AXI_CTRL, 32'h0);
      $display("test stack error reset done");
      wrap_up();
   end
endmodule : tb
bind csia_core csia_core_assertions chk_i (.*);
